// [verilog/ebm_misc_regs.sv]
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ebm_params.svh"
module ebm_misc_regs
  import ebm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] modeSel,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] portPinIn,
  input wire logic extIntPin,
  input wire logic pageValid,
  input wire logic [5:0] pageAddr,
  input wire logic emulCsReq,
  input wire logic extCsReq,
  input wire logic stretchedAccess,
  input wire logic internalAccess,
  output logic [7:0] portPinOut,
  output logic [7:0] portPinOe,
  output logic [7:0] portPullEn,
  output logic [3:0] lowDriveSel,
  output logic busClockOut,
  output logic extIntReq,
  output logic extBusCycle
);

  ebm_mode_t mode_q;
  logic [7:0] drive_q, data_q, dir_q;
  logic stretchEn_q, stretchWritten_q, edgeSense_q, edgeWritten_q, connect_q;
  logic emulSel_q, pullEn_q, edgeLatch_q;
  logic [2:0] pinSync_q;
  logic [7:0] portSync1_q, portSync2_q, portSync3_q, portIn_q;
  logic [1:0] divCnt_q;
  logic [7:0] awAddr_q, wData_q;
  logic wLane_q, pinHigh_q;

  // Mode is sampled once after reset release, never under the asynchronous reset.
  logic modeTaken_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= EBM_SPECIAL_SINGLE;
      modeTaken_q <= 1'b0;
    end else if (!modeTaken_q) begin
      mode_q <= ebm_mode_t'(modeSel);
      modeTaken_q <= 1'b1;
    end
  end

  logic singleChip, specialMode, expanded, miscMapped, portMapped, clkHold;
  always_comb begin
    clkHold = stretchEn_q && !singleChip && (stretchedAccess || internalAccess);
    singleChip = (mode_q == EBM_SPECIAL_SINGLE) || (mode_q == EBM_NORMAL_SINGLE);
    specialMode = (mode_q == EBM_SPECIAL_SINGLE) || (mode_q == EBM_SPECIAL_TEST) || (mode_q == EBM_PERIPHERAL);
    expanded = !singleChip && (mode_q != EBM_PERIPHERAL);
    miscMapped = singleChip;
    portMapped = !(emulSel_q && (expanded || mode_q == EBM_PERIPHERAL));
  end

  // Write channel: address and data accepted in either order, one at a time.
  logic doWrite, wEn;
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awAddr_q <= 8'h00;
      wData_q <= 8'h00;
      wLane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_q <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeOk(awAddr_q) ? `EBM_RESP_OKAY : `EBM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Unmapped or removed locations answer with an error; the access goes external only below the config offset.
  function automatic logic writeOk(input logic [7:0] a);
    case (a)
      `EBM_OFF_DRIVE, `EBM_OFF_STRETCH, `EBM_OFF_RSVD, `EBM_OFF_INTCTRL: writeOk = miscMapped;
      `EBM_OFF_PDATA, `EBM_OFF_PDIR: writeOk = portMapped;
      `EBM_OFF_CONFIG, `EBM_OFF_STATUS: writeOk = 1'b1;
      default: writeOk = 1'b0;
    endcase
  endfunction

  assign wEn = doWrite && wLane_q && writeOk(awAddr_q);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extBusCycle <= 1'b0;
    end else begin
      extBusCycle <= (doWrite && !writeOk(awAddr_q) && awAddr_q < `EBM_OFF_CONFIG)
                     || (s_axi_arvalid && s_axi_arready && !writeOk(s_axi_araddr[7:0])
                         && s_axi_araddr[7:0] < `EBM_OFF_CONFIG);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_q <= `EBM_RST_BYTE;
    end else if (wEn && awAddr_q == `EBM_OFF_DRIVE) begin
      drive_q <= wData_q & `EBM_DRIVE_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stretchEn_q <= 1'b0;
      stretchWritten_q <= 1'b0;
    end else if (wEn && awAddr_q == `EBM_OFF_STRETCH) begin
      stretchWritten_q <= 1'b1;
      if (specialMode || !stretchWritten_q) begin
        stretchEn_q <= wData_q[`EBM_BIT_STRETCH];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeSense_q <= 1'b0;
      edgeWritten_q <= 1'b0;
      connect_q <= 1'b0;
    end else if (wEn && awAddr_q == `EBM_OFF_INTCTRL) begin
      connect_q <= wData_q[`EBM_BIT_CONNECT];
      edgeWritten_q <= 1'b1;
      if (specialMode || !edgeWritten_q) begin
        edgeSense_q <= wData_q[`EBM_BIT_EDGE];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= `EBM_RST_BYTE;
      dir_q <= `EBM_RST_BYTE;
    end else if (wEn && awAddr_q == `EBM_OFF_PDATA) begin
      data_q <= wData_q;
    end else if (wEn && awAddr_q == `EBM_OFF_PDIR) begin
      dir_q <= wData_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emulSel_q <= 1'b0;
      pullEn_q <= 1'b0;
    end else if (wEn && awAddr_q == `EBM_OFF_CONFIG) begin
      emulSel_q <= wData_q[`EBM_BIT_EMUL];
      pullEn_q <= wData_q[`EBM_BIT_PULL];
    end
  end

  // Pin inputs cross in by three flops; a change counts when stages two and three agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync_q <= 3'b111;
      pinHigh_q <= 1'b1;
      portSync1_q <= 8'h00;
      portSync2_q <= 8'h00;
      portSync3_q <= 8'h00;
      portIn_q <= 8'h00;
    end else begin
      pinSync_q <= {pinSync_q[1:0], extIntPin};
      if (pinSync_q[1] == pinSync_q[2]) begin
        pinHigh_q <= pinSync_q[2];
      end
      portSync1_q <= portPinIn;
      portSync2_q <= portSync1_q;
      portSync3_q <= portSync2_q;
      portIn_q <= (portSync2_q & portSync3_q) | (portIn_q & (portSync2_q | portSync3_q));
    end
  end

  logic fallEdge, svcClear;
  assign fallEdge = pinSync_q[1] == pinSync_q[2] && !pinSync_q[2] && pinHigh_q;
  assign svcClear = wEn && awAddr_q == `EBM_OFF_STATUS && wData_q[`EBM_BIT_SVC];

  // Set wins over a service clear in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeLatch_q <= 1'b0;
    end else if (!connect_q) begin
      edgeLatch_q <= 1'b0;
    end else if (edgeSense_q && fallEdge) begin
      edgeLatch_q <= 1'b1;
    end else if (svcClear) begin
      edgeLatch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extIntReq <= 1'b0;
    end else begin
      extIntReq <= connect_q && (edgeSense_q ? edgeLatch_q : !pinHigh_q);
    end
  end

  // Bus clock: divider, stretched or parked only outside the single-chip modes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 2'd0;
      busClockOut <= 1'b0;
    end else begin
      if (!clkHold) begin
        divCnt_q <= divCnt_q + 2'd1;
      end
      if (stretchEn_q && !singleChip && stretchedAccess) begin
        busClockOut <= 1'b1;
      end else if (stretchEn_q && !singleChip && internalAccess) begin
        busClockOut <= 1'b0;
      end else begin
        busClockOut <= divCnt_q[1];
      end
    end
  end

  // Release is decoded at count zero, since the bus clock flop and the pin flop delay alike, so it fills the first half of the low phase.
  logic csRelease;
  assign csRelease = divCnt_q == 2'd0 && !clkHold && !(stretchedAccess && !stretchEn_q);

  generate
    for (genvar gi = 0; gi < 8; gi++) begin : gPin
      logic busOwned, busVal;
      if (gi == `EBM_CS_HI) begin : gEcs
        assign busVal = !emulCsReq || csRelease;
      end else if (gi == `EBM_CS_LO) begin : gXcs
        assign busVal = !extCsReq || csRelease;
      end else begin : gPage
        assign busVal = pageAddr[gi];
      end
      assign busOwned = emulSel_q && !singleChip && (gi >= `EBM_CS_LO || pageValid);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          portPinOut[gi] <= 1'b0;
          portPinOe[gi] <= 1'b0;
          portPullEn[gi] <= 1'b0;
        end else begin
          portPinOut[gi] <= busOwned ? busVal : data_q[gi];
          portPinOe[gi] <= busOwned || dir_q[gi];
          portPullEn[gi] <= pullEn_q && !(busOwned || dir_q[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowDriveSel <= 4'h0;
    end else begin
      lowDriveSel <= {drive_q[`EBM_BIT_DRV_UPPER], drive_q[`EBM_BIT_DRV_CTRL],
                      drive_q[`EBM_BIT_DRV_LOWD], drive_q[`EBM_BIT_DRV_HIGHD]};
    end
  end

  logic [7:0] rdVal;
  always_comb begin
    rdVal = 8'h00;
    case (s_axi_araddr[7:0])
      `EBM_OFF_DRIVE: rdVal = drive_q;
      `EBM_OFF_STRETCH: rdVal = {7'h00, stretchEn_q};
      `EBM_OFF_RSVD: rdVal = 8'h00;
      `EBM_OFF_INTCTRL: rdVal = {edgeSense_q, connect_q, 6'h00};
      `EBM_OFF_PDATA: rdVal = (dir_q & data_q) | (~dir_q & portIn_q);
      `EBM_OFF_PDIR: rdVal = dir_q;
      `EBM_OFF_CONFIG: rdVal = {6'h00, pullEn_q, emulSel_q};
      `EBM_OFF_STATUS: rdVal = {5'h00, mode_q == EBM_NORMAL_SINGLE, pinHigh_q, edgeLatch_q};
      default: rdVal = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EBM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= writeOk(s_axi_araddr[7:0]) ? {24'h000000, rdVal} : 32'h0000_0000;
      s_axi_rresp <= writeOk(s_axi_araddr[7:0]) ? `EBM_RESP_OKAY : `EBM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == `EBM_OFF_RSVD |=> s_axi_rdata == 32'h0)
    else $error("reserved read not zero");
  chk_stretch_once: assert property (@(posedge clk) disable iff (rst)
    !specialMode && stretchWritten_q && !$past(rst) |=> $stable(stretchEn_q))
    else $error("stretch bit changed after first write");
  chk_edge_once: assert property (@(posedge clk) disable iff (rst)
    !specialMode && edgeWritten_q |=> $stable(edgeSense_q))
    else $error("edge sense changed after first write");
  chk_latch_off: assert property (@(posedge clk) disable iff (rst) !connect_q |=> !edgeLatch_q)
    else $error("edge latch set while disconnected");
  chk_edge_capture: assert property (@(posedge clk) disable iff (rst)
    connect_q && edgeSense_q && fallEdge |=> edgeLatch_q ##1 extIntReq)
    else $error("falling edge not captured");
  chk_dir_oe: assert property (@(posedge clk) disable iff (rst) !emulSel_q |=> portPinOe == $past(dir_q))
    else $error("pin enable does not follow direction");
  chk_single_clk: assert property (@(posedge clk) disable iff (rst)
    singleChip && $past(singleChip) |-> busClockOut == $past(divCnt_q[1]))
    else $error("bus clock not free running in single chip");
  chk_misc_unmap: assert property (@(posedge clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && !singleChip && s_axi_araddr[7:0] == `EBM_OFF_DRIVE
    |=> s_axi_rresp == `EBM_RESP_SLVERR ##0 extBusCycle)
    else $error("drive register visible in expanded mode");
endmodule
`default_nettype wire

// [verilog/ebm_params.svh]
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define EBM_OFF_DRIVE 8'h00
`define EBM_OFF_STRETCH 8'h04
`define EBM_OFF_RSVD 8'h08
`define EBM_OFF_INTCTRL 8'h0c
`define EBM_OFF_PDATA 8'h10
`define EBM_OFF_PDIR 8'h14
`define EBM_OFF_CONFIG 8'h18
`define EBM_OFF_STATUS 8'h1c

// Field positions.
`define EBM_BIT_DRV_UPPER 7
`define EBM_BIT_DRV_CTRL 4
`define EBM_BIT_DRV_LOWD 1
`define EBM_BIT_DRV_HIGHD 0
`define EBM_DRIVE_MASK 8'h93
`define EBM_BIT_STRETCH 0
`define EBM_BIT_EDGE 7
`define EBM_BIT_CONNECT 6
`define EBM_BIT_EMUL 0
`define EBM_BIT_PULL 1
`define EBM_BIT_SVC 0
`define EBM_CS_HI 7
`define EBM_CS_LO 6

// Reset values.
`define EBM_RST_BYTE 8'h00

// Bus clock period in system clocks; chip select release lasts a quarter.
`define EBM_BUS_CLOCK_OUT_DIV 4
`define EBM_CS_RELEASE (`EBM_BUS_CLOCK_OUT_DIV / 4)

// AXI responses.
`define EBM_RESP_OKAY 2'b00
`define EBM_RESP_SLVERR 2'b10

`endif

// [verilog/ebm_pkg.sv]
`default_nettype none
package ebm_pkg;
  typedef enum logic [2:0] {
    EBM_SPECIAL_SINGLE,
    EBM_EMUL_NARROW,
    EBM_SPECIAL_TEST,
    EBM_EMUL_WIDE,
    EBM_NORMAL_SINGLE,
    EBM_NORMAL_NARROW,
    EBM_PERIPHERAL,
    EBM_NORMAL_WIDE
  } ebm_mode_t;
endpackage
`default_nettype wire

// [bench/ebm_ext_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ebm_ext_model (
  input wire logic clk,
  input wire logic [7:0] portPinOut,
  input wire logic [7:0] portPinOe,
  input wire logic [7:0] portPullEn,
  input wire logic [7:0] extDrive,
  input wire logic [7:0] extDriveEn,
  output logic [7:0] portPinIn
);
  logic [7:0] floatQ = 8'h00;
  // A released pin with no pull keeps changing, so a read of it can never match by luck.
  always @(posedge clk) floatQ <= ~floatQ;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (portPinOe[i]) portPinIn[i] = portPinOut[i];
      else if (extDriveEn[i]) portPinIn[i] = extDrive[i];
      else if (portPullEn[i]) portPinIn[i] = 1'b1;
      else portPinIn[i] = floatQ[i];
    end
  end
endmodule
`default_nettype wire

// [bench/ext_bus_misc_ctrl_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ebm_params.svh"
module ext_bus_misc_ctrl_regs_tb;
  // Response ready stays high, so back-to-back calls never lower and raise it in one step.
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, extIntPin = 1, pageValid = 0, emulCsReq = 0, extCsReq = 0;
  logic stretchedAccess = 0, internalAccess = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, busClockOut, extIntReq, extBusCycle;
  logic [2:0] modeSel = 3'h4;
  logic [3:0] s_axi_wstrb = 4'hf, lowDriveSel;
  logic [5:0] pageAddr = 6'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [7:0] portPinIn, portPinOut, portPinOe, portPullEn, extDrive = 0, extDriveEn = 0;
  int n_mismatch = 0, checked = 0, nExt = 0, hi, tg, e0;
  always #10 clk = ~clk;
  always @(posedge clk) if (extBusCycle === 1'b1) nExt++;
  ebm_misc_regs i_dut (.clk, .rst, .modeSel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portPinIn,
    .extIntPin, .pageValid, .pageAddr, .emulCsReq, .extCsReq, .stretchedAccess, .internalAccess, .portPinOut,
    .portPinOe, .portPullEn, .lowDriveSel, .busClockOut, .extIntReq, .extBusCycle);
  ebm_ext_model i_ext (.clk, .portPinOut, .portPinOe, .portPullEn, .extDrive, .extDriveEn, .portPinIn);
  task automatic final_report;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checked++;
    if (v !== e) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, v, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] v, input logic [1:0] e);
    checked++;
    if (v !== e) begin
      n_mismatch++;
      $display("[ERR] %0t response %b expected %b", $time, v, e);
    end
  endtask
  task automatic do_reset(input logic [2:0] m);
    rst <= 1'b1;
    modeSel <= m;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w && s_axi_bvalid === 1'b1));
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ar;
    ar = 0;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(ar && s_axi_rvalid === 1'b1));
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // Sixteen cycles of one output: b selects a port pin, 8 the bus clock.
  task automatic watch(input int b);
    logic p, s;
    hi = 0;
    tg = 0;
    @(posedge clk);
    p = (b == 8) ? busClockOut : portPinOut[b];
    repeat (16) begin
      @(posedge clk);
      s = (b == 8) ? busClockOut : portPinOut[b];
      hi += (s === 1'b1);
      tg += (s !== p);
      p = s;
    end
  endtask
  task automatic t_normal;
    do_reset(3'h4);
    for (int i = 0; i < 4; i++) begin
      rdr(8'(4 * i));
      chk(rd, 32'h0);
    end
    wr(`EBM_OFF_DRIVE, 32'hff);
    rdr(`EBM_OFF_DRIVE);
    chk(rd, 32'h93);
    chk(lowDriveSel, 4'hf);
    wr(`EBM_OFF_DRIVE, 32'h80);
    @(posedge clk);
    chk(lowDriveSel, 4'h8);
    wr(`EBM_OFF_RSVD, 32'hff);
    rdr(`EBM_OFF_RSVD);
    chk(rd, 32'h0);
    wr(`EBM_OFF_STRETCH, 32'hff);
    wr(`EBM_OFF_STRETCH, 32'h00);
    rdr(`EBM_OFF_STRETCH);
    chk(rd, 32'h1);
    wr(`EBM_OFF_INTCTRL, 32'hff);
    wr(`EBM_OFF_INTCTRL, 32'h00);
    rdr(`EBM_OFF_INTCTRL);
    chk(rd, 32'h80);
  endtask
  task automatic t_special;
    do_reset(3'h0);
    wr(`EBM_OFF_STRETCH, 32'h1);
    wr(`EBM_OFF_STRETCH, 32'h0);
    rdr(`EBM_OFF_STRETCH);
    chk(rd, 32'h0);
    wr(`EBM_OFF_STRETCH, 32'h1);
    stretchedAccess <= 1'b1;
    watch(8);
    chk(tg, 8);
    stretchedAccess <= 1'b0;
    wr(`EBM_OFF_INTCTRL, 32'hc0);
    wr(`EBM_OFF_INTCTRL, 32'h40);
    rdr(`EBM_OFF_INTCTRL);
    chk(rd, 32'h40);
  endtask
  task automatic pin_pulse;
    extIntPin <= 1'b0;
    repeat (8) @(posedge clk);
    extIntPin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_irq;
    do_reset(3'h0);
    wr(`EBM_OFF_INTCTRL, 32'hc0);
    pin_pulse();
    chk(extIntReq, 1'b1);
    rdr(`EBM_OFF_STATUS);
    chk(rd[0], 1'b1);
    wr(`EBM_OFF_STATUS, 32'h1);
    rdr(`EBM_OFF_STATUS);
    chk(rd[0], 1'b0);
    wr(`EBM_OFF_INTCTRL, 32'h80);
    pin_pulse();
    rdr(`EBM_OFF_STATUS);
    chk(rd[0], 1'b0);
    chk(extIntReq, 1'b0);
    wr(`EBM_OFF_INTCTRL, 32'h40);
    extIntPin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(extIntReq, 1'b1);
    extIntPin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(extIntReq, 1'b0);
  endtask
  task automatic t_port;
    do_reset(3'h4);
    wr(`EBM_OFF_PDATA, 32'ha5);
    wr(`EBM_OFF_PDIR, 32'h0f);
    extDrive <= 8'h50;
    extDriveEn <= 8'hf0;
    repeat (4) @(posedge clk);
    chk(portPinOe, 8'h0f);
    chk(portPinOut[3:0], 4'h5);
    rdr(`EBM_OFF_PDATA);
    chk(rd, 32'h55);
    extDriveEn <= 8'h00;
    wr(`EBM_OFF_CONFIG, 32'h3);
    repeat (6) @(posedge clk);
    rdr(`EBM_OFF_PDATA);
    chk_resp(rs, `EBM_RESP_OKAY);
    chk(rd, 32'hf5);
  endtask
  task automatic t_expanded;
    do_reset(3'h5);
    e0 = nExt;
    rdr(`EBM_OFF_DRIVE);
    chk_resp(rs, `EBM_RESP_SLVERR);
    wr(`EBM_OFF_INTCTRL, 32'h40);
    chk_resp(rs, `EBM_RESP_SLVERR);
    @(posedge clk);
    chk(nExt - e0, 2);
    stretchedAccess <= 1'b1;
    watch(8);
    chk(tg, 8);
    stretchedAccess <= 1'b0;
    wr(`EBM_OFF_CONFIG, 32'h1);
    rdr(`EBM_OFF_PDATA);
    chk_resp(rs, `EBM_RESP_SLVERR);
    rdr(`EBM_OFF_PDIR);
    chk_resp(rs, `EBM_RESP_SLVERR);
    pageValid <= 1'b1;
    pageAddr <= 6'h2a;
    emulCsReq <= 1'b1;
    repeat (4) @(posedge clk);
    chk(portPinOut[5:0], 6'h2a);
    watch(`EBM_CS_HI);
    chk(hi, 4);
    emulCsReq <= 1'b0;
    extCsReq <= 1'b1;
    repeat (4) @(posedge clk);
    watch(`EBM_CS_LO);
    chk(hi, 4);
    extCsReq <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    t_normal();
    t_special();
    t_irq();
    t_port();
    t_expanded();
    final_report();
  end
endmodule
`default_nettype wire
